//--- common/isa_id_pkg.sv
package isa_id_pkg;
   // register byte offsets on the bus
   localparam int ADDR_W = 8;
   localparam logic [7:0] WORD_ONE_OFS = 8'h00;
   localparam logic [7:0] WORD_TWO_OFS = 8'h04;
   localparam logic [7:0] WORD_THREE_OFS = 8'h08;
   localparam logic [7:0] WORD_FOUR_OFS = 8'h0c;
   localparam logic [7:0] CTRL_OFS = 8'h10;
   localparam logic [7:0] STAT_OFS = 8'h14;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // control and status layout
   localparam int CTRL_ERR_BIT = 0;
   localparam logic CTRL_ERR_RESET = 1'h0;
   localparam int STAT_SEEN_BIT = 0;
   localparam int STAT_CNT_POS = 8;
   localparam int CNT_W = 8;
   localparam int FIELD_W = 4;
   // word one, low half fields and upper half position
   localparam int SIGN_EXTEND_POS = 12;
   localparam logic [3:0] SIGN_EXTEND_CODE = 4'h2;
   localparam int APP_PROFILE_EXC_POS = 8;
   localparam logic [3:0] APP_PROFILE_EXC_CODE = 4'h1;
   localparam int EXC_RETURN_POS = 4;
   localparam logic [3:0] EXC_RETURN_CODE = 4'h1;
   localparam int BYTE_ORDER_POS = 0;
   localparam logic [3:0] BYTE_ORDER_CODE = 4'h1;
   localparam int WORD_ONE_UPPER_POS = 16;
   // word two
   localparam int REVERSAL_POS = 28;
   localparam logic [3:0] REVERSAL_CODE = 4'h2;
   localparam int STATUS_ACCESS_POS = 24;
   localparam logic [3:0] STATUS_ACCESS_CODE = 4'h1;
   localparam int UNSIGNED_MUL_POS = 20;
   localparam logic [3:0] UNSIGNED_MUL_CODE = 4'h2;
   localparam int SIGNED_MUL_POS = 16;
   localparam logic [3:0] SIGNED_MUL_CODE = 4'h3;
   localparam int BASIC_MUL_POS = 12;
   localparam logic [3:0] BASIC_MUL_CODE = 4'h2;
   localparam int MULTI_ACCESS_POS = 8;
   localparam logic [3:0] MULTI_ACCESS_CODE = 4'h0;
   localparam int MEMORY_HINT_POS = 4;
   localparam logic [3:0] MEMORY_HINT_CODE = 4'h4;
   localparam int EXTRA_LDST_POS = 0;
   localparam logic [3:0] EXTRA_LDST_CODE = 4'h2;
   // word three
   localparam int EXEC_ENV_POS = 28;
   localparam logic [3:0] EXEC_ENV_CODE = 4'h0;
   localparam int TRUE_NOP_POS = 24;
   localparam logic [3:0] TRUE_NOP_CODE = 4'h1;
   localparam int LOW_MOVE_POS = 20;
   localparam logic [3:0] LOW_MOVE_CODE = 4'h1;
   localparam int TABLE_BRANCH_POS = 16;
   localparam logic [3:0] TABLE_BRANCH_CODE = 4'h1;
   localparam int SYNC_PRIM_POS = 12;
   localparam int SUPERVISOR_CALL_POS = 8;
   localparam logic [3:0] SUPERVISOR_CALL_CODE = 4'h1;
   localparam int PACKED_SIMD_POS = 4;
   localparam int SATURATE_POS = 0;
   localparam logic [3:0] SATURATE_CODE = 4'h1;
   // word four
   localparam int SWAP_LOCK_POS = 28;
   localparam logic [3:0] SWAP_LOCK_CODE = 4'h0;
   localparam int PROFILE_M_POS = 24;
   localparam logic [3:0] PROFILE_M_CODE = 4'h0;
   localparam int SYNC_FRAC_POS = 20;
   localparam logic [3:0] SYNC_FRAC_CODE = 4'h0;
   localparam int BARRIER_POS = 16;
   localparam logic [3:0] BARRIER_CODE = 4'h1;
   localparam int SECURE_CALL_POS = 12;
   localparam logic [3:0] SECURE_CALL_CODE = 4'h0;
   localparam int WRITE_BACK_POS = 8;
   localparam logic [3:0] WRITE_BACK_CODE = 4'h1;
   localparam int SHIFT_SUPPORT_POS = 4;
   localparam logic [3:0] SHIFT_SUPPORT_CODE = 4'h4;
   localparam int WORD_FOUR_LOW_POS = 0;
endpackage

//--- design/sat_event_counter.sv
`timescale 1ns/1ns
// saturating event counter, an event and a clear in the same cycle restart the count at one
module sat_event_counter #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic inc,
   input wire logic clr,
   output logic [W-1:0] count
);
   // all ones means saturated, so a flood of writes cannot wrap to zero
   localparam logic [W-1:0] FULL = '1;
   localparam logic [W-1:0] ONE = W'(1);

   // count register, frozen while ce is low
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count <= '0;
      end
      else if (ce)
      begin
         // event with clear: restart from one, the event is kept
         if (inc && clr)
         begin
            count <= ONE;
         end
         else if (inc && count != FULL)
         begin
            count <= count + ONE;
         end
         else if (clr)
         begin
            count <= '0;
         end
      end
   end
endmodule // sat_event_counter

//--- design/isa_attribute_id_registers.sv
`timescale 1ns/1ns
// Summary of operation
// - word one extend field reads 0x2
// - word one profile exception field reads 0x1
// - word one exception return field reads 0x1
// - word one byte order field reads 0x1
// - 64-bit-only build may return any value
// - words two to four are read-only constants
// - word two reversal field reads 0x2
// - word two status access field reads 0x1
// - word two unsigned multiply field reads 0x2
// - word two signed multiply field reads 0x3
// - word two basic multiply field reads 0x2
// - word two multi-access field reads 0x0
// - word two memory hint field reads 0x4
// - word two extra load/store field reads 0x2
// - word three environment variant field reads 0x0
// - word three true no-op field reads 0x1
// - word three table branch field reads 0x1
// - word three supervisor call field reads 0x1
// - word three saturate field reads 0x1
// - word four swap locking field reads 0x0
// - word four barrier field reads 0x1
// - word four shift support field reads 0x4
module isa_attribute_id_registers #(
   parameter int ADDR_W = isa_id_pkg::ADDR_W,
   parameter bit ONLY_64BIT = 1'b0,
   parameter logic [15:0] WORD_ONE_UPPER = 16'h0000,
   parameter logic [3:0] SYNC_PRIM_CODE = 4'h0,
   parameter logic [3:0] PACKED_SIMD_CODE = 4'h0,
   parameter logic [3:0] WORD_FOUR_LOW_CODE = 4'h0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   // identification words as seen by software
   logic [31:0] word_one;
   logic [31:0] word_two;
   logic [31:0] word_three;
   logic [31:0] word_four;
   // write channel capture
   logic aw_got_q;
   logic w_got_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   // read channel
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   // control and status state
   logic err_on_id_write_q;
   logic write_seen_q;
   logic [isa_id_pkg::CNT_W-1:0] ignored_count;
   // decode strobes
   logic wr_fire;
   logic wr_id_hit;
   logic wr_ctrl_hit;
   logic wr_stat_hit;
   logic stat_clear;
   logic ar_fire;
   logic [31:0] rd_word;
   logic rd_hit;
   // word indexes of the map; address bits [1:0] are dropped, so compare at that width
   localparam logic [ADDR_W-3:0] ONE_IDX = (ADDR_W-2)'(isa_id_pkg::WORD_ONE_OFS >> 2);
   localparam logic [ADDR_W-3:0] TWO_IDX = (ADDR_W-2)'(isa_id_pkg::WORD_TWO_OFS >> 2);
   localparam logic [ADDR_W-3:0] THREE_IDX = (ADDR_W-2)'(isa_id_pkg::WORD_THREE_OFS >> 2);
   localparam logic [ADDR_W-3:0] FOUR_IDX = (ADDR_W-2)'(isa_id_pkg::WORD_FOUR_OFS >> 2);
   localparam logic [ADDR_W-3:0] CTRL_IDX = (ADDR_W-2)'(isa_id_pkg::CTRL_OFS >> 2);
   localparam logic [ADDR_W-3:0] STAT_IDX = (ADDR_W-2)'(isa_id_pkg::STAT_OFS >> 2);

   // word one: low fields fixed, upper half is a build parameter
   always_comb
   begin
      word_one = '0;
      word_one[isa_id_pkg::WORD_ONE_UPPER_POS +: 16] = WORD_ONE_UPPER;
      word_one[isa_id_pkg::SIGN_EXTEND_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::SIGN_EXTEND_CODE;
      word_one[isa_id_pkg::APP_PROFILE_EXC_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::APP_PROFILE_EXC_CODE;
      word_one[isa_id_pkg::EXC_RETURN_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::EXC_RETURN_CODE;
      word_one[isa_id_pkg::BYTE_ORDER_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::BYTE_ORDER_CODE;
   end

   // word two: all eight fields fixed
   always_comb
   begin
      word_two = '0;
      word_two[isa_id_pkg::REVERSAL_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::REVERSAL_CODE;
      word_two[isa_id_pkg::STATUS_ACCESS_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::STATUS_ACCESS_CODE;
      word_two[isa_id_pkg::UNSIGNED_MUL_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::UNSIGNED_MUL_CODE;
      word_two[isa_id_pkg::SIGNED_MUL_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::SIGNED_MUL_CODE;
      word_two[isa_id_pkg::BASIC_MUL_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::BASIC_MUL_CODE;
      word_two[isa_id_pkg::MULTI_ACCESS_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::MULTI_ACCESS_CODE;
      word_two[isa_id_pkg::MEMORY_HINT_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::MEMORY_HINT_CODE;
      word_two[isa_id_pkg::EXTRA_LDST_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::EXTRA_LDST_CODE;
   end

   // word three: two fields have no fixed code and come from parameters
   always_comb
   begin
      word_three = '0;
      word_three[isa_id_pkg::EXEC_ENV_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::EXEC_ENV_CODE;
      word_three[isa_id_pkg::TRUE_NOP_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::TRUE_NOP_CODE;
      word_three[isa_id_pkg::LOW_MOVE_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::LOW_MOVE_CODE;
      word_three[isa_id_pkg::TABLE_BRANCH_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::TABLE_BRANCH_CODE;
      word_three[isa_id_pkg::SYNC_PRIM_POS +: isa_id_pkg::FIELD_W] = SYNC_PRIM_CODE;
      word_three[isa_id_pkg::SUPERVISOR_CALL_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::SUPERVISOR_CALL_CODE;
      word_three[isa_id_pkg::PACKED_SIMD_POS +: isa_id_pkg::FIELD_W] = PACKED_SIMD_CODE;
      word_three[isa_id_pkg::SATURATE_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::SATURATE_CODE;
   end

   // word four: lowest field is a build parameter
   always_comb
   begin
      word_four = '0;
      word_four[isa_id_pkg::SWAP_LOCK_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::SWAP_LOCK_CODE;
      word_four[isa_id_pkg::PROFILE_M_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::PROFILE_M_CODE;
      word_four[isa_id_pkg::SYNC_FRAC_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::SYNC_FRAC_CODE;
      word_four[isa_id_pkg::BARRIER_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::BARRIER_CODE;
      word_four[isa_id_pkg::SECURE_CALL_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::SECURE_CALL_CODE;
      word_four[isa_id_pkg::WRITE_BACK_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::WRITE_BACK_CODE;
      word_four[isa_id_pkg::SHIFT_SUPPORT_POS +: isa_id_pkg::FIELD_W] =
         isa_id_pkg::SHIFT_SUPPORT_CODE;
      word_four[isa_id_pkg::WORD_FOUR_LOW_POS +: isa_id_pkg::FIELD_W] = WORD_FOUR_LOW_CODE;
   end

   // handshakes; nothing is taken while frozen, and one write at a time
   assign awready = ce && !aw_got_q && !bvalid_q;
   assign wready = ce && !w_got_q && !bvalid_q;
   assign arready = ce && !rvalid_q;
   assign ar_fire = arvalid && arready;
   assign wr_fire = ce && aw_got_q && w_got_q && !bvalid_q;

   // write decode on the captured address, low two bits ignored
   always_comb
   begin
      wr_id_hit = 1'b0;
      wr_ctrl_hit = 1'b0;
      wr_stat_hit = 1'b0;
      case (awaddr_q[ADDR_W-1:2])
         ONE_IDX,
         TWO_IDX,
         THREE_IDX,
         FOUR_IDX: wr_id_hit = 1'b1;
         CTRL_IDX: wr_ctrl_hit = 1'b1;
         STAT_IDX: wr_stat_hit = 1'b1;
         default: wr_id_hit = 1'b0; // unmapped
      endcase
   end

   // status clear is write-one to the seen bit through byte lane 0
   assign stat_clear = wr_fire && wr_stat_hit && wstrb_q[0] &&
      wdata_q[isa_id_pkg::STAT_SEEN_BIT];

   // write address capture
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aw_got_q <= 1'b0;
         awaddr_q <= '0;
      end
      else if (ce)
      begin
         if (awvalid && awready)
         begin
            aw_got_q <= 1'b1;
            awaddr_q <= awaddr;
         end
         else if (wr_fire)
         begin
            aw_got_q <= 1'b0;
         end
      end
   end

   // write data capture, may arrive before or after the address
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         w_got_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end
      else if (ce)
      begin
         if (wvalid && wready)
         begin
            w_got_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         else if (wr_fire)
         begin
            w_got_q <= 1'b0;
         end
      end
   end

   // write response; identification words store nothing
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= isa_id_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (wr_fire)
         begin
            bvalid_q <= 1'b1;
            // ignored id write answers as control selects
            if (wr_id_hit)
            begin
               bresp_q <= err_on_id_write_q ? isa_id_pkg::RESP_SLVERR : isa_id_pkg::RESP_OKAY;
            end
            else if (wr_ctrl_hit || wr_stat_hit)
            begin
               bresp_q <= isa_id_pkg::RESP_OKAY;
            end
            else
            begin
               bresp_q <= isa_id_pkg::RESP_SLVERR;
            end
         end
         else if (bready)
         begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // control register, only lane 0 carries a bit
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         err_on_id_write_q <= isa_id_pkg::CTRL_ERR_RESET;
      end
      else if (ce && wr_fire && wr_ctrl_hit && wstrb_q[0])
      begin
         err_on_id_write_q <= wdata_q[isa_id_pkg::CTRL_ERR_BIT];
      end
   end

   // sticky flag for an ignored id write; the set beats the clear
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         write_seen_q <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_fire && wr_id_hit)
         begin
            write_seen_q <= 1'b1;
         end
         else if (stat_clear)
         begin
            write_seen_q <= 1'b0;
         end
      end
   end

   // count of ignored id writes
   sat_event_counter #(
      .W(isa_id_pkg::CNT_W)
   ) u_ignored (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .inc(wr_fire && wr_id_hit),
      .clr(stat_clear),
      .count(ignored_count)
   );

   // read decode; a 64-bit-only build hides the words as zero
   always_comb
   begin
      rd_word = '0;
      rd_hit = 1'b1;
      case (araddr[ADDR_W-1:2])
         ONE_IDX: rd_word = ONLY_64BIT ? '0 : word_one;
         TWO_IDX: rd_word = ONLY_64BIT ? '0 : word_two;
         THREE_IDX: rd_word = ONLY_64BIT ? '0 : word_three;
         FOUR_IDX: rd_word = ONLY_64BIT ? '0 : word_four;
         CTRL_IDX: rd_word[isa_id_pkg::CTRL_ERR_BIT] = err_on_id_write_q;
         STAT_IDX:
         begin
            rd_word[isa_id_pkg::STAT_SEEN_BIT] = write_seen_q;
            rd_word[isa_id_pkg::STAT_CNT_POS +: isa_id_pkg::CNT_W] = ignored_count;
         end
         default: rd_hit = 1'b0; // unmapped reads zero with error
      endcase
   end

   // read data channel, held until rready
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= isa_id_pkg::RESP_OKAY;
      end
      else if (ce)
      begin
         if (ar_fire)
         begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? isa_id_pkg::RESP_OKAY : isa_id_pkg::RESP_SLVERR;
         end
         else if (rready)
         begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   chk_word_one_codes:
   assert property (ar_fire && araddr[ADDR_W-1:2] == ONE_IDX && !ONLY_64BIT |=>
      rdata[15:12] == 4'h2 && rdata[11:8] == 4'h1 && rdata[7:4] == 4'h1 &&
      rdata[3:0] == 4'h1 && rresp == 2'h0)
      else $error("word one codes wrong");
   chk_word_two_codes:
   assert property (ar_fire && araddr[ADDR_W-1:2] == TWO_IDX && !ONLY_64BIT |=>
      rdata == 32'h21232042)
      else $error("word two codes wrong");
   chk_word_three_codes:
   assert property (ar_fire && araddr[ADDR_W-1:2] == THREE_IDX && !ONLY_64BIT |=>
      rdata[31:24] == 8'h01 && rdata[19:16] == 4'h1 && rdata[11:8] == 4'h1 &&
      rdata[3:0] == 4'h1)
      else $error("word three codes wrong");
   chk_word_four_codes:
   assert property (ar_fire && araddr[ADDR_W-1:2] == FOUR_IDX && !ONLY_64BIT |=>
      rdata[31:28] == 4'h0 && rdata[19:16] == 4'h1 && rdata[7:4] == 4'h4)
      else $error("word four codes wrong");
   chk_narrow_build_zero:
   assert property (ar_fire && araddr[ADDR_W-1:2] <= FOUR_IDX && ONLY_64BIT |=>
      rdata == 32'h0)
      else $error("narrow build word not zero");
   chk_id_write_ignored:
   assert property (wr_fire && wr_id_hit |=> bvalid &&
      bresp == (err_on_id_write_q ? 2'h2 : 2'h0) && write_seen_q)
      else $error("id write not ignored as set");
   chk_unmapped_read:
   assert property (ar_fire && !rd_hit |=> rvalid && rresp == 2'h2 && rdata == 32'h0)
      else $error("unmapped read answer wrong");
   chk_read_held:
   assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer dropped early");
   chk_write_held:
   assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped early");

   cov_id_read: cover property (ar_fire && araddr[ADDR_W-1:2] == TWO_IDX);
   cov_id_write: cover property (wr_fire && wr_id_hit && err_on_id_write_q);
   cov_status_clear: cover property (stat_clear);
   cov_data_first: cover property (w_got_q && !aw_got_q ##1 wr_fire);
endmodule // isa_attribute_id_registers

//--- verif/isa_attribute_id_registers_tb_top.sv
`timescale 1ns/1ns
module isa_attribute_id_registers_tb_top;
   logic clk = 1'b0; // 25 mhz bench clock
   logic reset_n = 1'b0; // async reset, low while asserted
   logic ce = 1'b1; // clock enable
   logic [7:0] awaddr = 8'h00;
   logic [2:0] awprot = 3'h0;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic [2:0] arprot = 3'h0;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   int fails = 0; // mismatches seen
   int checked = 0; // comparisons made
   int cycles = 0; // hang guard
   int seed = 80; // fixed seed keeps runs repeatable
   int cnt = 0; // ignored id writes expected in status
   int idx;
   int jdx;
   logic [31:0] rd;
   logic [1:0] rs;
   // id word addresses in map order
   localparam logic [7:0] ADDRS [4] = '{isa_id_pkg::WORD_ONE_OFS, isa_id_pkg::WORD_TWO_OFS,
      isa_id_pkg::WORD_THREE_OFS, isa_id_pkg::WORD_FOUR_OFS};

   always #20 clk = ~clk;

   isa_attribute_id_registers u_isa_attribute_id_registers (.clk(clk), .reset_n(reset_n),
      .ce(ce), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));

   // expected words with default build parameters, unknown fields left at zero
   function automatic logic [31:0] exp_word(input int i);
      case (i)
         0: return {16'h0000, 4'h2, 4'h1, 4'h1, 4'h1};
         1: return {4'h2, 4'h1, 4'h2, 4'h3, 4'h2, 4'h0, 4'h4, 4'h2};
         2: return {4'h0, 4'h1, 4'h1, 4'h1, 4'h0, 4'h1, 4'h0, 4'h1};
         default: return {4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h1, 4'h4, 4'h0};
      endcase
   endfunction

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one four-bit field of a read word
   task automatic field(input logic [31:0] w, input int pos, input logic [3:0] e);
      check({28'h0, w[pos+:4]}, {28'h0, e});
   endtask

   // aw and w offered together, each dropped once taken, bready held until bvalid
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      awprot <= 3'($random(seed));
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   // read with rready held until rvalid is sampled
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arprot <= 3'($random(seed));
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // cut a hang short well past the expected run length
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         final_report();
      end
   end

   initial
   begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      // field codes of all four words after reset
      axi_rd(ADDRS[0], rd, rs);
      field(rd, 12, 4'h2);
      field(rd, 8, 4'h1);
      field(rd, 4, 4'h1);
      field(rd, 0, 4'h1);
      axi_rd(ADDRS[1], rd, rs);
      field(rd, 28, 4'h2);
      field(rd, 24, 4'h1);
      field(rd, 20, 4'h2);
      field(rd, 16, 4'h3);
      field(rd, 12, 4'h2);
      field(rd, 8, 4'h0);
      field(rd, 4, 4'h4);
      field(rd, 0, 4'h2);
      axi_rd(ADDRS[2], rd, rs);
      field(rd, 28, 4'h0);
      field(rd, 24, 4'h1);
      field(rd, 16, 4'h1);
      field(rd, 8, 4'h1);
      field(rd, 0, 4'h1);
      axi_rd(ADDRS[3], rd, rs);
      field(rd, 28, 4'h0);
      field(rd, 16, 4'h1);
      field(rd, 4, 4'h4);
      $display("test reset fields done");
      // random writes to id words must leave every word as it was
      for (int k = 0; k < 40; k++)
      begin
         idx = $unsigned($random(seed)) % 4;
         axi_wr(ADDRS[idx], $random(seed), 4'($random(seed)), rs);
         check({30'h0, rs}, {30'h0, isa_id_pkg::RESP_OKAY});
         cnt++;
         jdx = $unsigned($random(seed)) % 4;
         axi_rd(ADDRS[jdx], rd, rs);
         check(rd, exp_word(jdx));
         axi_rd(ADDRS[idx], rd, rs);
         check({30'h0, rs}, {30'h0, isa_id_pkg::RESP_OKAY});
         check(rd, exp_word(idx));
      end
      $display("test random writes done");
      // status counts the ignored writes, then clears
      axi_rd(isa_id_pkg::STAT_OFS, rd, rs);
      check(rd, {16'h0000, 8'(cnt), 7'h00, 1'b1});
      axi_wr(isa_id_pkg::STAT_OFS, 32'h00000001, 4'h1, rs);
      axi_rd(isa_id_pkg::STAT_OFS, rd, rs);
      check(rd, 32'h00000000);
      // error mode: id write refused with slverr, word untouched
      axi_wr(isa_id_pkg::CTRL_OFS, 32'h00000001, 4'h1, rs);
      axi_rd(isa_id_pkg::CTRL_OFS, rd, rs);
      check(rd, 32'h00000001);
      axi_wr(ADDRS[1], 32'hffffffff, 4'hf, rs);
      check({30'h0, rs}, {30'h0, isa_id_pkg::RESP_SLVERR});
      axi_rd(ADDRS[1], rd, rs);
      check(rd, exp_word(1));
      axi_wr(isa_id_pkg::CTRL_OFS, 32'h00000000, 4'h1, rs);
      $display("test status and control done");
      // unmapped place answers slverr with zero data
      axi_rd(8'h20, rd, rs);
      check({30'h0, rs}, {30'h0, isa_id_pkg::RESP_SLVERR});
      check(rd, 32'h00000000);
      axi_wr(8'h20, 32'h12345678, 4'hf, rs);
      check({30'h0, rs}, {30'h0, isa_id_pkg::RESP_SLVERR});
      // clock enable low refuses every new request channel
      @(posedge clk);
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      check({29'h0, awready, wready, arready}, 32'h00000000);
      ce <= 1'b1;
      $display("test unmapped and enable done");
      // reset in mid-run clears status, id words keep their codes
      axi_wr(ADDRS[0], 32'h0000ffff, 4'hf, rs);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      axi_rd(isa_id_pkg::STAT_OFS, rd, rs);
      check(rd, 32'h00000000);
      axi_rd(ADDRS[0], rd, rs);
      check(rd, exp_word(0));
      $display("test second reset done");
      final_report();
   end
endmodule // isa_attribute_id_registers_tb_top
